// >>> rtl/fpm_cfg.svh
/*
 * Offsets, field positions, reset values and timing counts for the
 * front panel menu controller.
 * Assumes it is included by bare name after fpm_pkg where types matter.
 */
`ifndef FPM_CFG_SVH
`define FPM_CFG_SVH

// Clock and power-up display phases
`define FPM_CLK_KHZ 10000
`define FPM_LAMP_MS 1000
`define FPM_VER_MS 1000
`define FPM_FW_VERSION 16'h0100

// Register map, byte addresses
`define FPM_ADDR_W 8
`define FPM_REG_STATUS 8'h00
`define FPM_REG_VERSION 8'h04
`define FPM_REG_SET0 8'h08
`define FPM_REG_SET1 8'h0c
`define FPM_REG_SET2 8'h10
`define FPM_REG_CTRL 8'h14
`define FPM_CTRL_LOCK 0

// Value limits
`define FPM_LEVEL_MIN (-16'sd10)
`define FPM_LEVEL_MAX (16'sd13)
`define FPM_GAIN_MIN (-16'sd10)
`define FPM_GAIN_MAX (16'sd10)
`define FPM_OFFS_MIN (-16'sd2000)
`define FPM_OFFS_MAX (16'sd2000)
`define FPM_MADDR_MIN (16'sd0)
`define FPM_MADDR_MAX (16'sd99)
`define FPM_MODE_LAST 3'h4
`define FPM_IFACE_LAST 2'h2

// Reset values of committed settings
`define FPM_LEVEL_RST 8'sh0a

`endif

// >>> rtl/fpm_pkg.sv
/*
 * Types of the front panel menu controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fpm_pkg;
   typedef enum logic [2:0] {
      MODE_INT, MODE_PASS, MODE_PASS_AUTO, MODE_LOCK, MODE_LOCK_AUTO
   } fpm_mode_t;
   typedef enum logic [1:0] {IF_232, IF_422, IF_485} fpm_iface_t;
   typedef enum logic [3:0] {
      MENU_NORMAL, MENU_MODE, MENU_LEVEL, MENU_OFFSET, MENU_REMOTE,
      MENU_IFACE, MENU_ADDR, MENU_SAVE
   } fpm_menu_t;
   typedef enum logic [1:0] {PH_TEST, PH_VER, PH_RUN} fpm_phase_t;
   typedef struct packed {
      fpm_mode_t mode;
      logic signed [7:0] level;
      logic signed [7:0] gain;
      logic signed [15:0] offset;
      logic remote;
      fpm_iface_t iface;
      logic [6:0] maddr;
   } fpm_settings_t;
endpackage : fpm_pkg

// >>> rtl/fpm_edit_if.sv
/*
 * Carrier between the menu controller and its digit editor.
 * Assumes the editor answers combinationally in the same cycle.
 */
`timescale 1ns/100ps
interface fpm_edit_if;
   logic signed [15:0] value;
   logic signed [15:0] lo;
   logic signed [15:0] hi;
   logic [2:0] pos;
   logic up;
   logic down;
   logic signed [15:0] result;
   modport user (output value, lo, hi, pos, up, down, input result);
   modport editor (input value, lo, hi, pos, up, down, output result);
endinterface : fpm_edit_if

// >>> rtl/fpm_digit_edit.sv
/*
 * Decimal digit editor: adds or takes the weight of the digit under
 * the cursor, clamped to the field's limits.
 * Assumes up and down are never both high.
 */
`timescale 1ns/100ps
module fpm_digit_edit (
   fpm_edit_if.editor ed
);
   logic signed [16:0] weight;
   logic signed [16:0] sum;

   always_comb begin
      unique case (ed.pos)
         3'h0: weight = 17'sd1;
         3'h1: weight = 17'sd10;
         3'h2: weight = 17'sd100;
         3'h3: weight = 17'sd1000;
         default: weight = 17'sd0;
      endcase
      sum = {ed.value[15], ed.value};
      if (ed.up) begin
         sum = sum + weight;
      end else if (ed.down) begin
         sum = sum - weight;
      end
      // Clamp rather than wrap, a digit never carries out of range
      // Signed compare, a bare concatenation would be unsigned
      if (sum > $signed({ed.hi[15], ed.hi})) begin
         ed.result = ed.hi;
      end else if (sum < $signed({ed.lo[15], ed.lo})) begin
         ed.result = ed.lo;
      end else begin
         ed.result = sum[15:0];
      end
   end
endmodule : fpm_digit_edit

// >>> rtl/fpm_powerup_seq.sv
/*
 * Power-up display sequencer: lamp test, then version, then run.
 * Assumes a free running clock from reset release onward.
 */
`timescale 1ns/100ps
module fpm_powerup_seq #(
   parameter int LAMP_CYC = 10,
   parameter int VER_CYC = 10
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   output fpm_pkg::fpm_phase_t phase_o
);
   logic [31:0] cnt;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         phase_o <= fpm_pkg::PH_TEST;
         cnt <= 32'h0;
      end else begin
         unique case (phase_o)
            fpm_pkg::PH_TEST: begin
               if (cnt == 32'(LAMP_CYC - 1)) begin
                  phase_o <= fpm_pkg::PH_VER;
                  cnt <= 32'h0;
               end else begin
                  cnt <= cnt + 32'h1;
               end
            end
            fpm_pkg::PH_VER: begin
               if (cnt == 32'(VER_CYC - 1)) begin
                  phase_o <= fpm_pkg::PH_RUN;
                  cnt <= 32'h0;
               end else begin
                  cnt <= cnt + 32'h1;
               end
            end
            fpm_pkg::PH_RUN: cnt <= 32'h0;
            default: phase_o <= fpm_pkg::PH_TEST;
         endcase
      end
   end
endmodule : fpm_powerup_seq

// >>> rtl/fpm_menu_ctrl.sv
/*
 * Front panel menu controller: switch decoding, staged settings,
 * commit at the save prompt, power-up display and a register port.
 * Assumes switch pulses are one cycle, clean and synchronous to mclk_i,
 * and that nv_data_i holds the stored image from reset release on.
 */
`timescale 1ns/100ps
`include "fpm_cfg.svh"
module fpm_menu_ctrl #(
   parameter int LAMP_CYC = `FPM_LAMP_MS * `FPM_CLK_KHZ,
   parameter int VER_CYC = `FPM_VER_MS * `FPM_CLK_KHZ
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Panel switches and option strap
   input wire logic exec_i,
   input wire logic left_i,
   input wire logic right_i,
   input wire logic up_i,
   input wire logic down_i,
   input wire logic option_i,
   // Nonvolatile settings image
   input wire logic [44:0] nv_data_i,
   output logic [44:0] nv_data_o,
   output logic nv_write_o,
   // Applied settings
   output logic [2:0] mode_o,
   output logic [7:0] level_o,
   output logic [7:0] gain_o,
   output logic [15:0] offset_o,
   output logic remote_o,
   output logic [1:0] iface_o,
   output logic [6:0] maddr_o,
   // Display
   output logic disp_lamp_o,
   output logic disp_ver_o,
   output logic [3:0] disp_page_o,
   output logic disp_gain_o,
   output logic [15:0] disp_value_o,
   output logic [2:0] disp_cursor_o,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o
);
   fpm_pkg::fpm_menu_t state;
   fpm_pkg::fpm_phase_t phase;
   fpm_pkg::fpm_settings_t staged;
   fpm_pkg::fpm_settings_t committed;
   logic [2:0] pos;
   logic [2:0] ndig;
   logic loaded;
   logic opt;
   logic lock;
   logic run;
   logic pass_sel;
   logic on_ret;
   logic go_exec;
   logic save_yes;
   logic digit_menu;

   fpm_edit_if ed ();

   fpm_digit_edit u_edit (
      .ed(ed.editor)
   );

   fpm_powerup_seq #(
      .LAMP_CYC(LAMP_CYC),
      .VER_CYC(VER_CYC)
   ) u_pwr (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .phase_o(phase)
   );

   ////////////////////////////////////////////////////////////////////
   // Decode

   function automatic logic is_pass(input fpm_pkg::fpm_mode_t m);
      is_pass = (m == fpm_pkg::MODE_PASS) || (m == fpm_pkg::MODE_PASS_AUTO);
   endfunction : is_pass

   assign run = (phase == fpm_pkg::PH_RUN) && loaded;
   assign go_exec = run && exec_i && !lock;
   // Gain form only exists with the option fitted
   assign pass_sel = opt && is_pass(staged.mode);
   assign on_ret = (pos == ndig);
   assign save_yes = go_exec && (state == fpm_pkg::MENU_SAVE) && (pos == 3'h0);

   always_comb begin
      unique case (state)
         fpm_pkg::MENU_LEVEL: ndig = 3'h2;
         fpm_pkg::MENU_OFFSET: ndig = 3'h4;
         fpm_pkg::MENU_ADDR: ndig = 3'h2;
         fpm_pkg::MENU_NORMAL: ndig = 3'h0;
         default: ndig = 3'h1;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Digit editor feed

   always_comb begin
      ed.value = 16'sh0;
      ed.lo = 16'sh0;
      ed.hi = 16'sh0;
      digit_menu = 1'b1;
      unique case (state)
         fpm_pkg::MENU_LEVEL: begin
            if (pass_sel) begin
               ed.value = 16'(staged.gain);
               ed.lo = `FPM_GAIN_MIN;
               ed.hi = `FPM_GAIN_MAX;
            end else begin
               ed.value = 16'(staged.level);
               ed.lo = `FPM_LEVEL_MIN;
               ed.hi = `FPM_LEVEL_MAX;
            end
         end
         fpm_pkg::MENU_OFFSET: begin
            ed.value = staged.offset;
            ed.lo = `FPM_OFFS_MIN;
            ed.hi = `FPM_OFFS_MAX;
         end
         fpm_pkg::MENU_ADDR: begin
            ed.value = {9'h0, staged.maddr};
            ed.lo = `FPM_MADDR_MIN;
            ed.hi = `FPM_MADDR_MAX;
         end
         default: digit_menu = 1'b0;
      endcase
   end

   assign ed.pos = pos;
   assign ed.up = run && !lock && up_i && digit_menu && !on_ret;
   assign ed.down = run && !lock && down_i && digit_menu && !on_ret;

   ////////////////////////////////////////////////////////////////////
   // Strap capture and nonvolatile reload

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         loaded <= 1'b0;
         opt <= 1'b0;
      end else if (!loaded) begin
         loaded <= 1'b1;
         opt <= option_i;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Menu sequence

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= fpm_pkg::MENU_NORMAL;
      end else if (go_exec) begin
         unique case (state)
            fpm_pkg::MENU_NORMAL: begin
               state <= opt ? fpm_pkg::MENU_MODE
                            : fpm_pkg::MENU_LEVEL;
            end
            fpm_pkg::MENU_SAVE: state <= fpm_pkg::MENU_NORMAL;
            default: begin
               if (on_ret || state == fpm_pkg::MENU_ADDR) begin
                  state <= fpm_pkg::MENU_SAVE;
               end else begin
                  state <= fpm_pkg::fpm_menu_t'(state + 4'h1);
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Cursor

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         pos <= 3'h0;
      end else if (go_exec) begin
         pos <= 3'h0;
      end else if (run && !lock && left_i && pos < ndig) begin
         pos <= pos + 3'h1;
      end else if (run && !lock && right_i && pos != 3'h0) begin
         pos <= pos - 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Staged edits

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         staged <= '0;
      end else if (go_exec && state == fpm_pkg::MENU_NORMAL) begin
         // Fresh copy each entry drops anything left unsaved
         staged <= committed;
      end else if (run && !lock && (up_i || down_i) && !on_ret) begin
         unique case (state)
            fpm_pkg::MENU_MODE: begin
               if (up_i) begin
                  staged.mode <= (staged.mode == `FPM_MODE_LAST)
                     ? fpm_pkg::MODE_INT
                     : fpm_pkg::fpm_mode_t'(staged.mode + 3'h1);
               end else begin
                  staged.mode <= (staged.mode == fpm_pkg::MODE_INT)
                     ? fpm_pkg::fpm_mode_t'(`FPM_MODE_LAST)
                     : fpm_pkg::fpm_mode_t'(staged.mode - 3'h1);
               end
            end
            fpm_pkg::MENU_LEVEL: begin
               if (pass_sel) begin
                  staged.gain <= ed.result[7:0];
               end else begin
                  staged.level <= ed.result[7:0];
               end
            end
            fpm_pkg::MENU_OFFSET: staged.offset <= ed.result;
            fpm_pkg::MENU_REMOTE: staged.remote <= !staged.remote;
            fpm_pkg::MENU_IFACE: begin
               if (up_i) begin
                  staged.iface <= (staged.iface == `FPM_IFACE_LAST)
                     ? fpm_pkg::IF_232
                     : fpm_pkg::fpm_iface_t'(staged.iface + 2'h1);
               end else begin
                  staged.iface <= (staged.iface == fpm_pkg::IF_232)
                     ? fpm_pkg::fpm_iface_t'(`FPM_IFACE_LAST)
                     : fpm_pkg::fpm_iface_t'(staged.iface - 2'h1);
               end
            end
            fpm_pkg::MENU_ADDR: staged.maddr <= ed.result[6:0];
            default: staged <= staged;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Committed settings

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         committed <= '0;
         committed.level <= `FPM_LEVEL_RST;
         nv_write_o <= 1'b0;
      end else begin
         nv_write_o <= save_yes;
         if (!loaded) begin
            committed <= fpm_pkg::fpm_settings_t'(nv_data_i);
         end else if (save_yes) begin
            committed <= staged;
         end
      end
   end

   assign nv_data_o = committed;
   assign mode_o = committed.mode;
   assign level_o = committed.level;
   assign gain_o = committed.gain;
   assign offset_o = committed.offset;
   assign remote_o = committed.remote;
   assign iface_o = committed.iface;
   assign maddr_o = committed.maddr;

   ////////////////////////////////////////////////////////////////////
   // Display

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         disp_lamp_o <= 1'b1;
         disp_ver_o <= 1'b0;
         disp_page_o <= 4'h0;
         disp_gain_o <= 1'b0;
         disp_value_o <= 16'h0;
         disp_cursor_o <= 3'h0;
      end else begin
         disp_lamp_o <= (phase == fpm_pkg::PH_TEST);
         disp_ver_o <= (phase == fpm_pkg::PH_VER);
         disp_page_o <= state;
         disp_cursor_o <= pos;
         if (state == fpm_pkg::MENU_NORMAL) begin
            disp_gain_o <= opt && is_pass(committed.mode);
            disp_value_o <= (opt && is_pass(committed.mode))
               ? 16'(committed.gain) : 16'(committed.level);
         end else begin
            disp_gain_o <= pass_sel;
            disp_value_o <= digit_menu ? ed.value : 16'(staged.mode);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Register port

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         lock <= 1'b0;
      end else if (wr_i && addr_i == `FPM_REG_CTRL) begin
         lock <= wdata_i[`FPM_CTRL_LOCK];
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 32'h0;
      end else if (rd_i) begin
         unique case (addr_i)
            `FPM_REG_STATUS: rdata_o <= {22'h0, opt, phase, state, pos};
            `FPM_REG_VERSION: rdata_o <= {16'h0, `FPM_FW_VERSION};
            `FPM_REG_SET0: begin
               rdata_o <= {13'h0, committed.mode, committed.gain,
                           committed.level};
            end
            `FPM_REG_SET1: rdata_o <= {16'h0, committed.offset};
            `FPM_REG_SET2: begin
               rdata_o <= {22'h0, committed.remote, committed.iface,
                           committed.maddr};
            end
            `FPM_REG_CTRL: rdata_o <= {31'h0, lock};
            default: rdata_o <= 32'h0;
         endcase
      end else begin
         rdata_o <= 32'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   a_level_range: assert property (
      staged.level >= -8'sd10 && staged.level <= 8'sd13)
      else $error("staged level out of range");
   a_gain_range: assert property (
      staged.gain >= -8'sd10 && staged.gain <= 8'sd10)
      else $error("staged gain out of range");
   a_offset_range: assert property (
      staged.offset >= -16'sd2000 && staged.offset <= 16'sd2000)
      else $error("staged offset out of range");
   a_mode_count: assert property (
      staged.mode <= 3'h4)
      else $error("mode code beyond five modes");
   a_commit_only_save: assert property (
      $past(loaded) && (committed != $past(committed))
      |-> $past(state) == fpm_pkg::MENU_SAVE && $past(pos) == 3'h0
          && $past(exec_i) && nv_write_o)
      else $error("settings changed without save");
   a_menu_order: assert property (
      go_exec && state == fpm_pkg::MENU_OFFSET && pos != 3'h4
      |=> state == fpm_pkg::MENU_REMOTE)
      else $error("offset menu not followed by remote");
   a_return_jump: assert property (
      go_exec && state != fpm_pkg::MENU_NORMAL
      && state != fpm_pkg::MENU_SAVE && on_ret
      |=> state == fpm_pkg::MENU_SAVE ##1 !nv_write_o)
      else $error("return did not reach save prompt");
   a_skip_mode: assert property (
      go_exec && state == fpm_pkg::MENU_NORMAL && !opt
      |=> state == fpm_pkg::MENU_LEVEL && pos == 3'h0)
      else $error("mode menu shown without option");
   a_cursor_step: assert property (
      run && !lock && !exec_i && right_i && !left_i && pos != 3'h0
      |=> pos == $past(pos) - 3'h1)
      else $error("cursor did not step right");
endmodule : fpm_menu_ctrl

// >>> tb/fpm_operator.sv
/*
 * Operator and settings store model for the menu controller.
 * Assumes the bench calls press() from a single procedure.
 */
`timescale 1ns/100ps
module fpm_operator (
   // Clock
   input wire logic mclk_i,
   // Store port
   input wire logic nv_write_i,
   input wire logic [44:0] nv_data_i,
   output logic [44:0] nv_image_o,
   // Switches
   output logic exec_o,
   output logic left_o,
   output logic right_o,
   output logic up_o,
   output logic down_o
);
   fpm_pkg::fpm_settings_t nv_q;

   assign nv_image_o = nv_q;

   initial begin
      nv_q = '{fpm_pkg::MODE_INT, 8'sh05, 8'sh03, 16'sh0000, 1'b0,
         fpm_pkg::IF_232, 7'h00};
      {exec_o, left_o, right_o, up_o, down_o} = 5'h00;
   end

   // Outlives controller resets, as a real store does
   always @(posedge mclk_i) begin
      if (nv_write_i) begin
         nv_q <= nv_data_i;
      end
   end

   // One clean pulse: 0 exec, 1 left, 2 right, 3 up, 4 down
   task automatic press(input int key);
      @(posedge mclk_i);
      {exec_o, left_o, right_o, up_o, down_o} <= 5'h10 >> key;
      @(posedge mclk_i);
      {exec_o, left_o, right_o, up_o, down_o} <= 5'h00;
      @(posedge mclk_i);
      #1;
   endtask : press
endmodule : fpm_operator

// >>> tb/front_panel_menu_controller_bench.sv
/*
 * Self-checking bench of the menu controller.
 * Assumes the operator model presses switches and keeps the store.
 */
`timescale 1ns/100ps
module front_panel_menu_controller_bench;
   localparam int E = 0, L = 1, R = 2, U = 3, D = 4;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic option_i = 1'b0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic exec_i, left_i, right_i, up_i, down_i;
   logic nv_write_o, remote_o, disp_lamp_o, disp_ver_o, disp_gain_o;
   logic [44:0] nv_image, nv_data_o;
   logic [2:0] mode_o, disp_cursor_o;
   logic [7:0] level_o, gain_o;
   logic [15:0] offset_o, disp_value_o;
   logic [1:0] iface_o;
   logic [6:0] maddr_o;
   logic [3:0] disp_page_o;
   logic [31:0] rdata_o;
   int num_errors = 0;
   int check_count = 0;
   int seed = 82;
   int n, nl, nv, bad;

   always #50 mclk_i = ~mclk_i;

   fpm_operator op (.mclk_i(mclk_i), .nv_write_i(nv_write_o),
      .nv_data_i(nv_data_o), .nv_image_o(nv_image), .exec_o(exec_i),
      .left_o(left_i), .right_o(right_i), .up_o(up_i), .down_o(down_i));

   fpm_menu_ctrl #(.LAMP_CYC(10), .VER_CYC(10)) dut (.mclk_i(mclk_i),
      .rst_i(rst_i), .exec_i(exec_i), .left_i(left_i), .right_i(right_i),
      .up_i(up_i), .down_i(down_i), .option_i(option_i),
      .nv_data_i(nv_image), .nv_data_o(nv_data_o),
      .nv_write_o(nv_write_o), .mode_o(mode_o), .level_o(level_o),
      .gain_o(gain_o), .offset_o(offset_o), .remote_o(remote_o),
      .iface_o(iface_o), .maddr_o(maddr_o), .disp_lamp_o(disp_lamp_o),
      .disp_ver_o(disp_ver_o), .disp_page_o(disp_page_o),
      .disp_gain_o(disp_gain_o), .disp_value_o(disp_value_o),
      .disp_cursor_o(disp_cursor_o), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));

   ////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [44:0] got, input logic [44:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic close_out;
      $display("checks=%0d errors=%0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : close_out

   task automatic hit(input int key, input int times);
      repeat (times) op.press(key);
   endtask : hit

   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1;
      chk(rdata_o, exp);
   endtask : reg_rd

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask : reg_wr

   // Phase lengths may come out one edge short or up to two edges long
   task automatic boot(input logic opt);
      @(posedge mclk_i);
      rst_i <= 1'b1;
      option_i <= opt;
      repeat (2) @(posedge mclk_i);
      #1;
      chk(disp_lamp_o, 1'b1);
      chk(level_o, 8'h0a);
      @(posedge mclk_i);
      rst_i <= 1'b0;
      nl = 0;
      nv = 0;
      bad = 0;
      repeat (30) begin
         @(posedge mclk_i);
         #1;
         nl += disp_lamp_o;
         nv += disp_ver_o;
         if ((disp_lamp_o && nv > 0) || (disp_ver_o && disp_lamp_o)) begin
            bad = 1;
         end
      end
      chk(bad, 0);
      chk(nl inside {[9:12]}, 1'b1);
      chk(nv inside {[9:12]}, 1'b1);
      reg_rd(8'h00, {22'h0, opt, 2'h2, 7'h00});
   endtask : boot

   ////////////////////////////////////////////////////////////////////
   initial begin
      boot(1'b0);
      chk(level_o, 8'h05);
      reg_rd(8'h04, 32'h0000_0100);
      reg_rd(8'h20, 32'h0);
      reg_rd(8'h08, 32'h0000_0305);
      $display("test boot done");
      hit(E, 1);
      chk(disp_page_o, 4'h2);
      chk(disp_gain_o, 1'b0);
      n = $random(seed) & 7;
      hit(U, n);
      chk(disp_value_o, 16'((n > 8) ? 13 : 5 + n));
      hit(U, 9);
      chk(disp_value_o, 16'h000d);
      hit(L, 3);
      chk(disp_cursor_o, 3'h2);
      hit(R, 1);
      chk(disp_cursor_o, 3'h1);
      hit(L, 1);
      hit(E, 1);
      chk(disp_page_o, 4'h7);
      hit(L, 1);
      chk(disp_cursor_o, 3'h1);
      hit(E, 1);
      chk(disp_page_o, 4'h0);
      chk(level_o, 8'h05);
      reg_wr(8'h14, 32'h1);
      hit(E, 1);
      chk(disp_page_o, 4'h0);
      reg_wr(8'h14, 32'h0);
      hit(E, 1);
      hit(U, 8);
      hit(E, 1);
      chk(disp_page_o, 4'h3);
      hit(E, 4);
      chk(disp_page_o, 4'h7);
      hit(E, 1);
      chk(level_o, 8'h0d);
      $display("test no option done");
      boot(1'b1);
      chk(level_o, 8'h0d);
      hit(E, 1);
      chk(disp_page_o, 4'h1);
      for (n = 1; n <= 6; n++) begin
         hit(U, 1);
         chk(disp_value_o, 16'(n % 5));
      end
      hit(E, 1);
      chk(disp_gain_o, 1'b1);
      hit(D, 15);
      chk(disp_value_o, 16'hfff6);
      hit(E, 1);
      hit(L, 3);
      hit(U, 3);
      chk(disp_value_o, 16'd2000);
      hit(E, 1);
      hit(U, 1);
      hit(E, 1);
      hit(U, 2);
      hit(E, 1);
      hit(L, 1);
      hit(U, 12);
      chk(disp_value_o, 16'd99);
      hit(E, 2);
      chk(mode_o, 3'h1);
      chk(gain_o, 8'hf6);
      chk(offset_o, 16'd2000);
      chk(remote_o, 1'b1);
      chk(iface_o, 2'h2);
      chk(maddr_o, 7'd99);
      reg_rd(8'h10, {22'h0, 1'b1, 2'h2, 7'd99});
      $display("test option done");
      close_out;
   end

   initial begin
      #400000;
      num_errors++;
      close_out;
   end
endmodule : front_panel_menu_controller_bench
